// [pcmso_defines.svh]
// register offsets, field positions, reset values and counts of the pcm serial output
`ifndef PCMSO_DEFINES_SVH
`define PCMSO_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define PCMSO_ADDR_DIVIDER   8'h54
`define PCMSO_ADDR_FORMAT    8'h55
`define PCMSO_ADDR_ROUTE     8'h56
`define PCMSO_ADDR_MIX       8'h49
`define PCMSO_RST_DIVIDER    8'h01
`define PCMSO_RST_FORMAT     8'h21
`define PCMSO_RST_ROUTE      8'h00
`define PCMSO_RST_MIX        8'h00
`define PCMSO_FMT_MASK       8'h7F
`define PCMSO_ROUTE_MASK     8'h03

// ****************************************
// format field positions
// ****************************************
`define PCMSO_BIT_LSB_FIRST  6
`define PCMSO_BIT_PAD_SIDE   5
`define PCMSO_BIT_LR_POL     4
`define PCMSO_BIT_ALT_FMT    3
`define PCMSO_BIT_EDGE       2
`define PCMSO_WIDTH_HI       1
`define PCMSO_WIDTH_LO       0

// ****************************************
// widths and slot counts
// ****************************************
`define PCMSO_SAMPLE_W       24
`define PCMSO_SLOTS_NARROW   6'h1F
`define PCMSO_SLOTS_WIDE     6'h3F
`define PCMSO_HALF_NARROW    6'h10
`define PCMSO_HALF_WIDE      6'h20
`define PCMSO_FIFO_DEPTH     8
`define PCMSO_MUTE_DB        8'h60

`endif

// [pcmso_pkg.sv]
// types shared by the pcm serial output files
package pcmso_pkg;
    `include "pcmso_defines.svh"

    typedef struct packed {
        logic [`PCMSO_SAMPLE_W-1:0] left;
        logic [`PCMSO_SAMPLE_W-1:0] right;
    } pcmso_pair_t;

    typedef enum logic [1:0] {
        PCMSO_W16 = 2'h0,
        PCMSO_W18 = 2'h1,
        PCMSO_W20 = 2'h2,
        PCMSO_W24 = 2'h3
    } pcmso_width_t;

    typedef enum logic [1:0] {
        PCMSO_ROUTE_STRAIGHT = 2'h0,
        PCMSO_ROUTE_LEFT_DUP = 2'h1,
        PCMSO_ROUTE_RIGHT_DUP = 2'h2,
        PCMSO_ROUTE_SWAP     = 2'h3
    } pcmso_route_t;

    typedef enum logic [1:0] {
        PCMSO_ST_IDLE = 2'b01,
        PCMSO_ST_RUN  = 2'b10
    } pcmso_state_t;
endpackage

// [pcmso_fifo.sv]
// sample-pair fifo with valid/ready on both sides
`timescale 1ns/1ps
module pcmso_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // draining side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;
    wire [AW:0]       next_count = count + (AW+1)'(doPush) - (AW+1)'(doPop);

    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    always_ff @(posedge core_clk) begin
        if (doPush) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            // ready is a flop so the port never carries a combinational path
            inReady <= 1'b1;
        end else begin
            if (doPush) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count   <= next_count;
            inReady <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

// [pcmso_mixer.sv]
// channel routing and right-into-left cross mix
`timescale 1ns/1ps
module pcmso_mixer (
    // settings
    input  wire logic [1:0]         routeSel,
    input  wire logic [7:0]         mixLevel,
    // samples
    input  wire pcmso_pkg::pcmso_pair_t inPair,
    output pcmso_pkg::pcmso_pair_t  outPair
);
    import pcmso_pkg::*;

    // 1 dB per unit: 6 dB per halving plus a fractional gain step
    function automatic logic signed [23:0] attenuate(input logic signed [23:0] s,
                                                     input logic [7:0] db);
        logic [7:0]         whole;
        logic [2:0]         frac;
        logic [8:0]         gain;
        logic signed [33:0] prod;
        whole = db / 8'h06;
        frac  = 3'(db - whole * 8'h06);
        case (frac)
            3'h0:    gain = 9'h100;
            3'h1:    gain = 9'h0E4;
            3'h2:    gain = 9'h0CB;
            3'h3:    gain = 9'h0B5;
            3'h4:    gain = 9'h0A1;
            default: gain = 9'h090;
        endcase
        prod = (34'(s) * $signed({1'b0, gain})) >>> 8;
        attenuate = 24'(prod >>> whole);
    endfunction

    wire pcmso_route_t route = pcmso_route_t'(routeSel);
    logic signed [23:0] routedL;
    logic signed [23:0] routedR;

    always_comb begin
        case (route)
            PCMSO_ROUTE_LEFT_DUP: begin
                routedL = inPair.left;
                routedR = inPair.left;
            end
            PCMSO_ROUTE_RIGHT_DUP: begin
                routedL = inPair.right;
                routedR = inPair.right;
            end
            PCMSO_ROUTE_SWAP: begin
                routedL = inPair.right;
                routedR = inPair.left;
            end
            default: begin
                routedL = inPair.left;
                routedR = inPair.right;
            end
        endcase
    end

    // a zero level fully closes the redirected path
    wire signed [23:0] redirected = (mixLevel == 8'h00) ? 24'sh000000
                                  : attenuate(routedR, mixLevel);
    wire signed [24:0] sum = 25'(routedL) + 25'(redirected);
    // saturate so a loud mix clips instead of wrapping round
    wire sumOver  = (sum[24] != sum[23]);
    wire [23:0] satMax = {1'b0, {23{1'b1}}};
    wire [23:0] satMin = {1'b1, {23{1'b0}}};

    assign outPair.left  = sumOver ? (sum[24] ? satMin : satMax) : sum[23:0];
    assign outPair.right = routedR;
endmodule

// [pcmso_serial_out.sv]
// serial pcm output toward an external dac: registers, clocks, framing and serialiser
// ****************************************
// Summary of operation
// - mix level zero mutes right-into-left path; otherwise the right is mixed in.
// - each unit of attenuation value adds one decibel; zero mutes the path.
// - bit clock is oversampling clock divided by 2*(1+divider).
// - frame spans 2*(1+div)*32 cycles at 16 bit, *64 when wider.
// - format bit six set sends least significant bit first.
// - bit five chooses pad side, only for 18, 20 and 24 bit widths.
// - bit four set: word select low for left, high for right.
// - bit three chooses standard or alternative format; zero after reset.
// - bit two set launches data on rising edge, else falling; resets zero.
// - width field 00,01,10,11 selects 16, 18, 20, 24 bit samples.
// - 32 bits per frame at 16 bit, 64 bits per frame otherwise.
// - route field: straight, left duplicated, right duplicated, swapped; resets zero.
// ****************************************
`timescale 1ns/1ps
module pcmso_serial_out (
    // clock and reset (core_clk is the oversampling clock)
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // register port
    input  wire logic                   regWrEn,
    input  wire logic                   regRdEn,
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    output logic [7:0]                  regRdData,
    // decoded sample stream
    input  wire pcmso_pkg::pcmso_pair_t pcmPair,
    input  wire logic                   pcmValid,
    output logic                        pcmReady,
    // dac pins
    output logic                        serialBitClockOut,
    output logic                        wordSelectOut,
    output logic                        serialDataOut,
    // status
    output logic                        underrun
);
    import pcmso_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] bitClockDivider;
    logic [7:0] serialFormatConfig;
    logic [7:0] channelRouteSelect;
    logic [7:0] rightToLeftMixLevel;

    wire hitDiv   = (regAddr == `PCMSO_ADDR_DIVIDER);
    wire hitFmt   = (regAddr == `PCMSO_ADDR_FORMAT);
    wire hitRoute = (regAddr == `PCMSO_ADDR_ROUTE);
    wire hitMix   = (regAddr == `PCMSO_ADDR_MIX);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitClockDivider     <= `PCMSO_RST_DIVIDER;
            serialFormatConfig  <= `PCMSO_RST_FORMAT;
            channelRouteSelect  <= `PCMSO_RST_ROUTE;
            rightToLeftMixLevel <= `PCMSO_RST_MIX;
        end else if (regWrEn) begin
            if (hitDiv) begin
                bitClockDivider <= regWrData;
            end
            if (hitFmt) begin
                serialFormatConfig <= regWrData & `PCMSO_FMT_MASK;
            end
            if (hitRoute) begin
                channelRouteSelect <= regWrData & `PCMSO_ROUTE_MASK;
            end
            if (hitMix) begin
                rightToLeftMixLevel <= regWrData;
            end
        end
    end

    wire [7:0] next_regRdData = hitDiv   ? bitClockDivider
                              : hitFmt   ? serialFormatConfig
                              : hitRoute ? channelRouteSelect
                              : hitMix   ? rightToLeftMixLevel
                              : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= next_regRdData;
        end
    end

    // ****************************************
    // decoded format fields
    // ****************************************
    wire          lsbFirstSelect = serialFormatConfig[`PCMSO_BIT_LSB_FIRST];
    wire          padSide        = serialFormatConfig[`PCMSO_BIT_PAD_SIDE];
    wire          lrPolarity     = serialFormatConfig[`PCMSO_BIT_LR_POL];
    wire          altFormat      = serialFormatConfig[`PCMSO_BIT_ALT_FMT];
    wire          risingLaunch   = serialFormatConfig[`PCMSO_BIT_EDGE];
    wire pcmso_width_t sampleWidthSelect =
        pcmso_width_t'(serialFormatConfig[`PCMSO_WIDTH_HI:`PCMSO_WIDTH_LO]);
    wire          wideFrame = (sampleWidthSelect != PCMSO_W16);

    wire [5:0] lastSlot = wideFrame ? `PCMSO_SLOTS_WIDE : `PCMSO_SLOTS_NARROW;
    wire [5:0] halfSize = wideFrame ? `PCMSO_HALF_WIDE : `PCMSO_HALF_NARROW;

    function automatic logic [5:0] widthBits(input pcmso_width_t w);
        case (w)
            PCMSO_W18: widthBits = 6'h12;
            PCMSO_W20: widthBits = 6'h14;
            PCMSO_W24: widthBits = 6'h18;
            default:   widthBits = 6'h10;
        endcase
    endfunction

    wire [5:0] validBits = widthBits(sampleWidthSelect);

    // picks the bit of a left-aligned 24-bit sample for slot k of its half
    function automatic logic pickBit(input logic [23:0] s, input logic [5:0] k,
                                     input logic [5:0] half, input logic [5:0] w,
                                     input logic padLeft, input logic lsbFirst);
        logic [5:0] j;
        logic [5:0] lead;
        lead = padLeft ? 6'(half - w) : 6'h00;
        j = 6'(k - lead);
        if (k < lead || j >= w) begin
            pickBit = 1'b0;
        end else if (lsbFirst) begin
            pickBit = s[5'(6'd24 - w + j)];
        end else begin
            pickBit = s[5'(6'd23 - j)];
        end
    endfunction

    // ****************************************
    // sample supply
    // ****************************************
    pcmso_pair_t fifoPair;
    pcmso_pair_t mixedPair;
    logic        fifoValid;
    logic        fifoPop;

    pcmso_fifo #(
        .WIDTH ($bits(pcmso_pair_t)),
        .DEPTH (`PCMSO_FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inData   (pcmPair),
        .inValid  (pcmValid),
        .inReady  (pcmReady),
        .outData  (fifoPair),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    pcmso_mixer u_mixer (
        .routeSel (channelRouteSelect[1:0]),
        .mixLevel (rightToLeftMixLevel),
        .inPair   (fifoPair),
        .outPair  (mixedPair)
    );

    // ****************************************
    // bit clock generation
    // ****************************************
    pcmso_state_t state;
    logic [7:0]   phaseCnt;
    logic [5:0]   slot;
    logic [23:0]  curLeft;
    logic [23:0]  curRight;

    wire running   = (state == PCMSO_ST_RUN);
    // half a bit-clock period is 1+divider oversampling cycles
    wire phaseEnd  = running && (phaseCnt == bitClockDivider);
    wire next_sck  = ~serialBitClockOut;
    wire launch    = phaseEnd && (next_sck == risingLaunch);

    // ****************************************
    // framing
    // ****************************************
    wire [5:0] next_slot  = (slot >= lastSlot) ? 6'h00 : 6'(slot + 1'b1);
    // standard format delays data one slot behind word select
    wire       dataDelay  = ~altFormat;
    wire [5:0] dataPos    = (dataDelay && next_slot == 6'h00) ? lastSlot
                          : 6'(next_slot - 6'(dataDelay));
    wire       dataRight  = (dataPos >= halfSize);
    wire [5:0] dataK      = dataRight ? 6'(dataPos - halfSize) : dataPos;
    wire       slotRight  = (next_slot >= halfSize);
    wire       loadPair   = launch && (dataPos == 6'h00);
    // pad side only matters above 16 bits
    wire       padLeft    = padSide && wideFrame;

    assign fifoPop = loadPair && fifoValid;

    wire [23:0] useLeft  = fifoPop ? mixedPair.left  : 24'h000000;
    wire [23:0] useRight = fifoPop ? mixedPair.right : 24'h000000;
    wire [23:0] srcSample = dataRight ? (loadPair ? useRight : curRight)
                                      : (loadPair ? useLeft  : curLeft);
    wire next_data = pickBit(srcSample, dataK, halfSize, validBits,
                             padLeft, lsbFirstSelect);
    wire next_ws   = ~(slotRight ^ lrPolarity);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PCMSO_ST_IDLE;
        end else begin
            case (state)
                PCMSO_ST_IDLE: begin
                    if (fifoValid) begin
                        state <= PCMSO_ST_RUN;
                    end
                end
                PCMSO_ST_RUN: begin
                    state <= PCMSO_ST_RUN;
                end
                default: begin
                    state <= PCMSO_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseCnt          <= 8'h00;
            serialBitClockOut <= 1'b0;
        end else if (phaseEnd) begin
            phaseCnt          <= 8'h00;
            serialBitClockOut <= next_sck;
        end else if (running) begin
            phaseCnt          <= 8'(phaseCnt + 1'b1);
        end
    end

    // slot resets to 63, the last wide slot and past the narrow one, so the first launch opens a frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot          <= `PCMSO_SLOTS_WIDE;
            wordSelectOut <= 1'b0;
            serialDataOut <= 1'b0;
        end else if (launch) begin
            slot          <= next_slot;
            wordSelectOut <= next_ws;
            serialDataOut <= next_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            curLeft  <= 24'h000000;
            curRight <= 24'h000000;
            underrun <= 1'b0;
        end else begin
            // an empty fifo at frame start sends silence rather than stale data
            underrun <= loadPair && !fifoValid;
            if (loadPair) begin
                curLeft  <= useLeft;
                curRight <= useRight;
            end
        end
    end
endmodule

// [pcmso_serial_out_asserts.sv]
// port-level assertions on the pcm serial output, bound into the design
`timescale 1ns/1ps
`include "pcmso_defines.svh"
module pcmso_serial_out_chk (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    // register port
    input wire logic                   regWrEn,
    input wire logic                   regRdEn,
    input wire logic [7:0]             regAddr,
    input wire logic [7:0]             regWrData,
    input wire logic [7:0]             regRdData,
    // sample stream
    input wire pcmso_pkg::pcmso_pair_t pcmPair,
    input wire logic                   pcmValid,
    input wire logic                   pcmReady,
    // dac pins and status
    input wire logic                   serialBitClockOut,
    input wire logic                   wordSelectOut,
    input wire logic                   serialDataOut,
    input wire logic                   underrun
);
    import pcmso_pkg::*;
    logic [7:0]  divSh, fmtSh, routeSh, mixSh, sckCnt, expRd;
    logic [15:0] wsCnt, halfCycles;
    logic        sckSeen, wsSeen;
    // shadow copies of the registers, kept from the write port alone
    assign expRd = regAddr == `PCMSO_ADDR_DIVIDER ? divSh :
                   regAddr == `PCMSO_ADDR_FORMAT ? fmtSh :
                   regAddr == `PCMSO_ADDR_ROUTE ? routeSh :
                   regAddr == `PCMSO_ADDR_MIX ? mixSh : 8'h00;
    assign halfCycles = (fmtSh[1:0] == 2'h0 ? 16'h0020 : 16'h0040) * ({8'h00, divSh} + 16'h0001)
                        - 16'h0001;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            divSh <= 8'h01;
            fmtSh <= 8'h21;
            routeSh <= 8'h00;
            mixSh <= 8'h00;
        end else if (regWrEn) begin
            if (regAddr == `PCMSO_ADDR_DIVIDER) divSh <= regWrData;
            if (regAddr == `PCMSO_ADDR_FORMAT) fmtSh <= regWrData & 8'h7F;
            if (regAddr == `PCMSO_ADDR_ROUTE) routeSh <= regWrData & 8'h03;
            if (regAddr == `PCMSO_ADDR_MIX) mixSh <= regWrData;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sckCnt <= 8'h00;
            wsCnt <= 16'h0000;
            sckSeen <= 1'b0;
            wsSeen <= 1'b0;
        end else begin
            sckCnt <= $changed(serialBitClockOut) ? 8'h00 : sckCnt + {7'h00, sckCnt != 8'hFF};
            wsCnt <= $changed(wordSelectOut) ? 16'h0000 : wsCnt + {15'h0000, wsCnt != 16'hFFFF};
            sckSeen <= sckSeen | $changed(serialBitClockOut);
            wsSeen <= wsSeen | $changed(wordSelectOut);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_launch;
        $changed(serialBitClockOut) && serialBitClockOut == fmtSh[2];
    endsequence
    sequence s_left;
        wordSelectOut == !fmtSh[4];
    endsequence
    property p_read_back;
        regRdEn |=> regRdData == $past(expRd);
    endproperty
    property p_bit_clock;
        $changed(serialBitClockOut) && sckSeen |-> sckCnt == divSh;
    endproperty
    property p_ws_launch;
        $changed(wordSelectOut) |-> s_launch;
    endproperty
    property p_data_launch;
        $changed(serialDataOut) |-> s_launch;
    endproperty
    property p_half_len;
        $changed(wordSelectOut) && wsSeen |-> wsCnt == halfCycles;
    endproperty
    property p_ws_hold;
        $changed(wordSelectOut) |=> $stable(wordSelectOut) [*8];
    endproperty
    property p_data_hold;
        $changed(serialDataOut) |=> $stable(serialDataOut);
    endproperty
    property p_underrun;
        underrun |-> s_left ##1 !underrun;
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("register read value wrong");
    a_bit_clock: assert property (p_bit_clock)
        else $error("bit clock half period wrong");
    a_ws_launch: assert property (p_ws_launch)
        else $error("word select moved off the launch edge");
    a_data_launch: assert property (p_data_launch)
        else $error("data moved off the launch edge");
    a_half_len: assert property (p_half_len)
        else $error("channel half length wrong");
    a_ws_hold: assert property (p_ws_hold)
        else $error("word select half too short");
    a_data_hold: assert property (p_data_hold)
        else $error("data slot too short");
    a_underrun: assert property (p_underrun)
        else $error("underrun pulse outside left half");
endmodule
bind pcmso_serial_out pcmso_serial_out_chk u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .pcmPair(pcmPair),
    .pcmValid(pcmValid), .pcmReady(pcmReady), .serialBitClockOut(serialBitClockOut),
    .wordSelectOut(wordSelectOut), .serialDataOut(serialDataOut), .underrun(underrun)
);

// [pcmso_dac_model.sv]
// behavioural dac receiver: collects one word per channel half
`timescale 1ns/1ps
module pcmso_dac_model (
    // link pins
    input  wire logic   rst_n,
    input  wire logic   serialBitClockOut,
    input  wire logic   wordSelectOut,
    input  wire logic   serialDataOut,
    // receiver setup
    input  wire logic   sampleOnRise,
    input  wire logic   lagOneSlot,
    // received half word, last 32 bits with the first slot highest
    output logic        rxValid,
    output logic [31:0] rxWord,
    output logic [5:0]  rxCount,
    output logic        rxLevel
);
    logic [31:0] shiftReg;
    logic [5:0]  bitCount;
    logic        wsDelayed, wsEff, wsLast;
    initial {rxValid, rxWord, rxCount, rxLevel} = '0;
    always @(negedge rst_n) begin
        bitCount = 6'h00;
        wsDelayed = 1'b0;
        wsLast = 1'b0;
    end
    always @(serialBitClockOut) begin
        if (rst_n === 1'b1 && serialBitClockOut === sampleOnRise) begin
            rxValid = 1'b0;
            // standard format: ws leads the data by one slot
            wsEff = lagOneSlot ? wsDelayed : wordSelectOut;
            wsDelayed = wordSelectOut;
            if (wsEff !== wsLast) begin
                rxWord = shiftReg;
                rxCount = bitCount;
                rxLevel = wsLast;
                rxValid = 1'b1;
                bitCount = 6'h00;
            end
            wsLast = wsEff;
            shiftReg = {shiftReg[30:0], serialDataOut};
            if (bitCount != 6'h3F) bitCount = bitCount + 6'h01;
        end
    end
endmodule

// [tb_pcmso.sv]
// self-checking bench of the pcm serial output against the dac model
`timescale 1ns/1ps
`include "pcmso_defines.svh"
module tb;
    import pcmso_pkg::*;
    logic        core_clk, rst_n, regWrEn, regRdEn, pcmValid, pcmReady;
    logic        sck, ws, sdata, underrun, rxValid, rxLevel;
    logic [7:0]  regAddr, regWrData, regRdData, fmt;
    logic [31:0] rxWord;
    logic [5:0]  rxCount;
    pcmso_pair_t pcmPair;
    int          miscompares, compares, sawFull, sawUnder;
    logic [32:0] streamQ[$];
    logic [7:0]  readQ[$];
    logic [7:0]  cfgFmt[5] = '{8'h10, 8'h4D, 8'h36, 8'h6B, 8'h4C};
    logic [1:0]  cfgRoute[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    int          cfgOfac[5] = '{64, 128, 256, 128, 128};
    wire [5:0]   halfSlots = fmt[1:0] == 2'h0 ? 6'h10 : 6'h20;
    wire [31:0]  halfMask = fmt[1:0] == 2'h0 ? 32'h0000FFFF : 32'hFFFFFFFF;
    pcmso_serial_out uut (
        .core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .pcmPair(pcmPair),
        .pcmValid(pcmValid), .pcmReady(pcmReady), .serialBitClockOut(sck),
        .wordSelectOut(ws), .serialDataOut(sdata), .underrun(underrun));
    pcmso_dac_model dac (
        .rst_n(rst_n), .serialBitClockOut(sck), .wordSelectOut(ws), .serialDataOut(sdata),
        .sampleOnRise(~fmt[2]), .lagOneSlot(~fmt[3]), .rxValid(rxValid), .rxWord(rxWord),
        .rxCount(rxCount), .rxLevel(rxLevel));
    // ****************************************
    // checking helpers
    // ****************************************
    task automatic check(string name, logic [32:0] seen, logic [32:0] expv);
        compares++;
        if (seen !== expv) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, expv, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // slots of one half in send order, first slot in the top bit
    function automatic logic [31:0] exp_half(logic [23:0] s, logic [7:0] f);
        int w, h, k;
        logic [31:0] r;
        w = (f[1:0] == 2'h3) ? 24 : 16 + 2 * f[1:0];
        h = (f[1:0] == 2'h0) ? 16 : 32;
        r = 32'h0;
        for (int i = 0; i < h; i++) begin
            k = f[5] ? i - (h - w) : i;
            if (k >= 0 && k < w) r[h - 1 - i] = f[6] ? s[24 - w + k] : s[23 - k];
        end
        return r;
    endfunction
    task automatic reg_acc(logic rd, logic [7:0] a, logic [7:0] d);
        if (rd) readQ.push_back(d);
        regAddr <= a;
        regWrData <= d;
        {regRdEn, regWrEn} <= {rd, !rd};
        @(posedge core_clk);
        {regRdEn, regWrEn} <= 2'b00;
        @(posedge core_clk);
    endtask
    task automatic push_pair(pcmso_pair_t p, logic [1:0] rt);
        streamQ.push_back({~fmt[4], exp_half(rt[1] ? p.right : p.left, fmt)});
        streamQ.push_back({fmt[4], exp_half(rt[0] ? p.left : p.right, fmt)});
        pcmPair <= p;
        pcmValid <= 1'b1;
        @(negedge core_clk);
        while (pcmReady !== 1'b1) begin
            sawFull = 1;
            @(negedge core_clk);
        end
        @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (regRdEn === 1'b1) begin
            @(negedge core_clk);
            check("read data", {25'h0, regRdData}, {25'h0, readQ.pop_front()});
        end
    end
    always @(posedge rxValid) begin
        if (rxCount >= halfSlots && streamQ.size() > 0)
            check("half word", {rxLevel, rxWord & halfMask}, streamQ.pop_front());
    end
    always @(negedge core_clk) if (underrun === 1'b1) sawUnder = 1;
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #1000000;
        miscompares++;
        give_verdict();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n, regWrEn, regRdEn, pcmValid, regAddr, regWrData} = '0;
        pcmPair = '0;
        fmt = 8'h21;
        miscompares = 0;
        compares = 0;
        void'($urandom(32'h4689E1C2));
        for (int c = 0; c < 5; c++) begin
            rst_n <= 1'b0;
            repeat (6) @(posedge core_clk);
            rst_n <= 1'b1;
            @(posedge core_clk);
            if (c == 0) begin
                reg_acc(1, `PCMSO_ADDR_DIVIDER, 8'h01);
                reg_acc(1, `PCMSO_ADDR_FORMAT, 8'h21);
                reg_acc(1, `PCMSO_ADDR_ROUTE, 8'h00);
                reg_acc(1, `PCMSO_ADDR_MIX, 8'h00);
                reg_acc(0, `PCMSO_ADDR_FORMAT, 8'hFF);
                reg_acc(0, `PCMSO_ADDR_ROUTE, 8'hFF);
                reg_acc(0, 8'h57, 8'hA5);
                reg_acc(0, `PCMSO_ADDR_MIX, 8'h5A);
                reg_acc(1, `PCMSO_ADDR_FORMAT, 8'h7F);
                reg_acc(1, `PCMSO_ADDR_ROUTE, 8'h03);
                reg_acc(1, 8'h57, 8'h00);
                reg_acc(1, `PCMSO_ADDR_MIX, 8'h5A);
                reg_acc(0, `PCMSO_ADDR_MIX, 8'h00);
            end
            fmt = cfgFmt[c];
            sawFull = 0;
            sawUnder = 0;
            reg_acc(0, `PCMSO_ADDR_FORMAT, cfgFmt[c]);
            reg_acc(0, `PCMSO_ADDR_ROUTE, {6'h00, cfgRoute[c]});
            reg_acc(0, `PCMSO_ADDR_DIVIDER, 8'(cfgFmt[c][1:0] == 2'h0 ? cfgOfac[c] / 64 - 1 :
                                              cfgOfac[c] / 128 - 1));
            repeat (10) push_pair({24'($urandom), 24'($urandom)}, cfgRoute[c]);
            pcmValid <= 1'b0;
            while (sawUnder == 0) @(posedge core_clk);
            repeat (64) @(posedge core_clk);
            check("pairs left", 33'(streamQ.size()), 33'h0);
            check("fifo refused", 33'(sawFull), 33'h1);
        end
        give_verdict();
    end
endmodule
